// ==== include/txser_pkg.sv ====
package txser_pkg;
  // register addresses (special-register and extended-register space)
  localparam logic [15:0] TXSER_CTRL_ADDR = 16'h00a9;
  localparam logic [15:0] TXSER_TIMING_ADDR = 16'h00aa;
  localparam logic [15:0] TXSER_DATA_ADDR = 16'h00ab;
  localparam logic [15:0] TXSER_RATEL_ADDR = 16'h00ac;
  localparam logic [15:0] TXSER_RATEH_ADDR = 16'h00ad;
  localparam logic [15:0] TXSER_LEVEL_ADDR = 16'h00ce;
  localparam logic [15:0] TXSER_TRIM_ADDR = 16'h4012;
  localparam logic [15:0] TXSER_STATUS_ADDR = 16'h00b0;
  localparam logic [7:0] TXSER_CTRL_RST = 8'h00;
  localparam logic [7:0] TXSER_TIMING_RST = 8'h00;
  localparam logic [7:0] TXSER_DATA_RST = 8'h00;
  localparam logic [14:0] TXSER_RATE_RST = 15'h0000;
  localparam logic [7:0] TXSER_LEVEL_RST = 8'h00;
  localparam logic [7:0] TXSER_TRIM_RST = 8'h00;
  // control field positions
  localparam int TXSER_EN_BIT = 0;
  localparam int TXSER_FPA_BIT = 1;
  localparam int TXSER_FDIV_BIT = 2;
  localparam int TXSER_FOSC_BIT = 3;
  localparam int TXSER_FSK_BIT = 4;
  localparam int TXSER_FDEV_BIT = 5;
  localparam int TXSER_END_LSB = 6;
  // timing, level and trim field positions; ramp step count
  localparam int TXSER_CKDIV_LSB = 0;
  localparam int TXSER_EDGE_LSB = 3;
  localparam int TXSER_GW_LSB = 5;
  localparam int TXSER_SLICE_LSB = 3;
  localparam int TXSER_MAXDRV_BIT = 4;
  localparam int TXSER_RAMP_STEPS = 8;
  // end-of-data actions
  localparam logic [1:0] TXSER_END_OFF = 2'h0;
  localparam logic [1:0] TXSER_END_REPEAT = 2'h1;
  localparam logic [1:0] TXSER_END_ZEROS = 2'h2;
  localparam logic [1:0] TXSER_END_ONES = 2'h3;
  typedef enum logic [1:0] {
    TXSER_IDLE, TXSER_WARM, TXSER_SEND, TXSER_DOWN
  } txser_state_e;
endpackage

// ==== src/txser_clkdiv.sv ====
module txser_clkdiv
  import txser_pkg::*;
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  input wire logic [2:0] div_i,
  output logic tick_o
);
  logic [2:0] cnt_reg;
  // one tick every div_i+1 system clocks: the serializer clock enable
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= 3'h0;
      tick_o <= 1'b0;
    end else if (!run_i || cnt_reg >= div_i) begin
      cnt_reg <= 3'h0;
      tick_o <= run_i;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
      tick_o <= 1'b0;
    end
  end
endmodule

// ==== src/txser_top.sv ====
// Functional notes
// - out of data at group end: 00 power down, 01 repeat, 10 zeros, 11 ones
// - modulation select 0 is on-off keying, 1 is frequency-shift keying
// - force bits keep divider and oscillator powered regardless of state
// - force amplifier keeps it on and passes slice count unshaped
// - group length is group-width field plus one, one to eight symbols
// - new group width applies to the group loaded by next data write
// - amplifier ramps over 8 times divide factor times edge factor clocks
// - serializer clock is system clock divided by clock-divide plus one
// - one-byte holding register lets next group load while shifting
// - FSK drives a 7-bit deviation bus following current symbol
// - divider, oscillator powered only around transmission; amplifier too, but it stays on if enable clears while ramped up
// - test features: fixed pattern recirculation and forced FSK deviation
// - data write clears empty flag, one registered pulse; data LSB first
// - symbol period is rate field times divide factor system clocks
// - slice count sets number of enabled amplifier driver slices
module txser_top
  import txser_pkg::*;
#(
  parameter logic [6:0] DEV_OFFSET = 7'h40
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic pa_on_o,
  output logic [4:0] pa_slices_o,
  output logic pa_max_drive_o,
  output logic div_on_o,
  output logic osc_on_o,
  output logic [6:0] fsk_dev_o,
  output logic sym_o,
  output logic empty_o
);
  logic [7:0] ctrl_reg, timing_reg, data_reg, level_reg, trim_reg;
  logic [14:0] rate_reg;
  logic load_pulse_reg, full_reg;
  logic [7:0] shift_reg;
  logic [2:0] gw_cur_reg, bit_cnt_reg;
  logic [14:0] rate_cnt_reg;
  logic [4:0] ramp_reg;
  logic [4:0] ramp_cnt_reg;
  logic ramp_up_reg;
  txser_state_e state_reg;
  logic tick;
  logic sym_end, grp_end, en;
  logic [1:0] end_mode;
  logic [4:0] edge_lim;
  logic [14:0] rate_last;
  logic [7:0] grp_mask, rot;
  logic [4:0] slice_fld;
  logic [9:0] ramp_prod;
  // every edge takes the same number of steps, whatever the slice target
  localparam logic [4:0] RAMP_TOP = 5'(TXSER_RAMP_STEPS);

  assign en = ctrl_reg[TXSER_EN_BIT];
  assign end_mode = ctrl_reg[TXSER_END_LSB +: 2];
  // per-step ramp length in divided clocks: edge factor, times 8 steps
  assign edge_lim = {3'h0, timing_reg[TXSER_EDGE_LSB +: 2]};
  assign slice_fld = level_reg[TXSER_SLICE_LSB +: 5];
  assign ramp_prod = {5'h00, slice_fld} * {5'h00, ramp_reg};

  txser_clkdiv u_div (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .run_i(en),
    .div_i(timing_reg[TXSER_CKDIV_LSB +: 3]),
    .tick_o(tick)
  );

  // register writes
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_reg <= TXSER_CTRL_RST;
      timing_reg <= TXSER_TIMING_RST;
      data_reg <= TXSER_DATA_RST;
      rate_reg <= TXSER_RATE_RST;
      level_reg <= TXSER_LEVEL_RST;
      trim_reg <= TXSER_TRIM_RST;
    end else if (wr_i) begin
      unique case (addr_i)
        TXSER_CTRL_ADDR: ctrl_reg <= wdata_i;
        TXSER_TIMING_ADDR: timing_reg <= wdata_i;
        TXSER_DATA_ADDR: data_reg <= wdata_i;
        TXSER_RATEL_ADDR: rate_reg[7:0] <= wdata_i;
        TXSER_RATEH_ADDR: rate_reg[14:8] <= wdata_i[6:0];
        TXSER_LEVEL_ADDR: level_reg <= wdata_i;
        // only the max-drive bit is implemented; other bits read zero
        TXSER_TRIM_ADDR: trim_reg[TXSER_MAXDRV_BIT] <=
          wdata_i[TXSER_MAXDRV_BIT];
        default: ;
      endcase
    end
  end

  // registered write pulse: data is already stable when the shifter sees it
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      load_pulse_reg <= 1'b0;
    end else begin
      load_pulse_reg <= wr_i && addr_i == TXSER_DATA_ADDR;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
    end else begin
      unique case (addr_i)
        TXSER_CTRL_ADDR: rdata_o <= ctrl_reg;
        TXSER_TIMING_ADDR: rdata_o <= timing_reg;
        TXSER_DATA_ADDR: rdata_o <= data_reg;
        TXSER_RATEL_ADDR: rdata_o <= rate_reg[7:0];
        TXSER_RATEH_ADDR: rdata_o <= {1'b0, rate_reg[14:8]};
        TXSER_LEVEL_ADDR: rdata_o <= level_reg;
        TXSER_TRIM_ADDR: rdata_o <= trim_reg;
        TXSER_STATUS_ADDR: rdata_o <= {5'h00, state_reg,
          ~full_reg && ~load_pulse_reg};
        default: rdata_o <= 8'h00;
      endcase
    end
  end

  // a rate field of 0 behaves like 1 instead of stalling the symbol clock
  assign rate_last = (rate_reg == 15'h0000) ? 15'h0000 : rate_reg - 15'h1;
  assign sym_end = tick && rate_cnt_reg >= rate_last;
  assign grp_end = sym_end && bit_cnt_reg == gw_cur_reg;
  // rotate within the group; bits above it are dropped so that repeat
  // mode recirculates exactly the group and nothing else
  assign grp_mask = (8'h01 << gw_cur_reg) - 8'h01;
  assign rot = ((shift_reg >> 1) & grp_mask) |
    ((8'h01 << gw_cur_reg) & {8{shift_reg[0]}});

  // holding register occupancy; a new write wins over the transfer
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      full_reg <= 1'b0;
    end else if (load_pulse_reg) begin
      full_reg <= 1'b1;
    end else if (!en) begin
      full_reg <= full_reg;
    end else if ((state_reg == TXSER_IDLE ||
                  (state_reg == TXSER_SEND && grp_end)) && full_reg) begin
      full_reg <= 1'b0;
    end
  end

  // sequencer and shifter
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= TXSER_IDLE;
      shift_reg <= 8'h00;
      gw_cur_reg <= 3'h1;
      bit_cnt_reg <= 3'h0;
      rate_cnt_reg <= 15'h0000;
    end else if (!en) begin
      state_reg <= TXSER_IDLE;
      bit_cnt_reg <= 3'h0;
      rate_cnt_reg <= 15'h0000;
    end else begin
      if (tick) begin
        rate_cnt_reg <= sym_end ? 15'h0000 : rate_cnt_reg + 15'h1;
      end
      unique case (state_reg)
        TXSER_IDLE: begin
          if (full_reg && !load_pulse_reg) begin
            shift_reg <= data_reg;
            gw_cur_reg <= timing_reg[TXSER_GW_LSB +: 3];
            state_reg <= TXSER_WARM;
          end
        end
        TXSER_WARM: begin
          // start on a tick so the first symbol is as long as the others
          if (tick &&
              (ramp_reg == RAMP_TOP || ctrl_reg[TXSER_FPA_BIT])) begin
            state_reg <= TXSER_SEND;
            bit_cnt_reg <= 3'h0;
            rate_cnt_reg <= 15'h0000;
          end
        end
        TXSER_SEND: begin
          if (grp_end) begin
            bit_cnt_reg <= 3'h0;
            if (full_reg && !load_pulse_reg) begin
              shift_reg <= data_reg;
              gw_cur_reg <= timing_reg[TXSER_GW_LSB +: 3];
            end else begin
              unique case (end_mode)
                TXSER_END_OFF: state_reg <= TXSER_DOWN;
                TXSER_END_REPEAT: shift_reg <= rot;
                TXSER_END_ZEROS: shift_reg <= 8'h00;
                TXSER_END_ONES: shift_reg <= 8'hff;
              endcase
            end
          end else if (sym_end) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg <= rot;
          end
        end
        TXSER_DOWN: begin
          if (ramp_reg == 5'h00) begin
            state_reg <= TXSER_IDLE;
          end
        end
      endcase
    end
  end

  // amplifier edge shaping: one slice step per 8th of the edge time
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ramp_reg <= 5'h00;
      ramp_cnt_reg <= 5'h00;
      ramp_up_reg <= 1'b0;
    end else begin
      ramp_up_reg <= en && (state_reg == TXSER_WARM ||
        (state_reg == TXSER_SEND &&
         (ctrl_reg[TXSER_FSK_BIT] || shift_reg[0])));
      if (tick) begin
        if (ramp_cnt_reg >= edge_lim) begin
          ramp_cnt_reg <= 5'h00;
          if (ramp_up_reg && ramp_reg < RAMP_TOP) begin
            ramp_reg <= ramp_reg + 5'h1;
          end else if (!ramp_up_reg && ramp_reg != 5'h00) begin
            ramp_reg <= ramp_reg - 5'h1;
          end
        end else begin
          ramp_cnt_reg <= ramp_cnt_reg + 5'h1;
        end
      end
    end
  end

  // outputs
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pa_on_o <= 1'b0;
      pa_slices_o <= 5'h00;
      pa_max_drive_o <= 1'b0;
      div_on_o <= 1'b0;
      osc_on_o <= 1'b0;
      fsk_dev_o <= 7'h00;
      sym_o <= 1'b0;
      empty_o <= 1'b1;
    end else begin
      if (ctrl_reg[TXSER_FPA_BIT]) begin
        pa_on_o <= 1'b1;
        pa_slices_o <= level_reg[TXSER_SLICE_LSB +: 5];
      end else begin
        pa_on_o <= ramp_reg != 5'h00;
        // slices scale with the step so each edge takes eight equal steps
        pa_slices_o <= ramp_prod[7:3];
      end
      pa_max_drive_o <= trim_reg[TXSER_MAXDRV_BIT];
      div_on_o <= ctrl_reg[TXSER_FDIV_BIT] ||
        (en && state_reg != TXSER_IDLE);
      osc_on_o <= ctrl_reg[TXSER_FOSC_BIT] ||
        (en && state_reg != TXSER_IDLE);
      sym_o <= state_reg == TXSER_SEND && shift_reg[0];
      if (ctrl_reg[TXSER_FSK_BIT] &&
          (ctrl_reg[TXSER_FDEV_BIT] ||
           (state_reg == TXSER_SEND && shift_reg[0]))) begin
        fsk_dev_o <= DEV_OFFSET;
      end else begin
        fsk_dev_o <= 7'h00;
      end
      empty_o <= ~full_reg && ~load_pulse_reg;
    end
  end
endmodule

// ==== tb/txser_checker.sv ====
module txser_checker
  import txser_pkg::*;
#(
  parameter logic [6:0] DEV_OFFSET = 7'h40
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic pa_on_o,
  input wire logic [4:0] pa_slices_o,
  input wire logic pa_max_drive_o,
  input wire logic div_on_o,
  input wire logic osc_on_o,
  input wire logic [6:0] fsk_dev_o,
  input wire logic sym_o,
  input wire logic empty_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] c_reg, l_reg, t_reg;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // shadows of what firmware wrote, so outputs can be tied to settings
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      c_reg <= 8'h00;
      l_reg <= 8'h00;
      t_reg <= 8'h00;
    end else if (wr_i) begin
      if (addr_i == TXSER_CTRL_ADDR) c_reg <= wdata_i;
      if (addr_i == TXSER_LEVEL_ADDR) l_reg <= wdata_i;
      if (addr_i == TXSER_TRIM_ADDR) t_reg <= wdata_i;
    end
  end
  chk_empty_fall: assert property (
    wr_i && addr_i == TXSER_DATA_ADDR |-> ##3 !empty_o)
    else $error("empty flag did not fall after data write");
  chk_force_div: assert property (
    c_reg[TXSER_FDIV_BIT] [*3] |-> div_on_o)
    else $error("divider not held on");
  chk_force_osc: assert property (
    c_reg[TXSER_FOSC_BIT] [*3] |-> osc_on_o)
    else $error("oscillator not held on");
  chk_force_amp: assert property (
    (c_reg[TXSER_FPA_BIT] && $stable(l_reg)) [*3]
    |-> pa_on_o && pa_slices_o == l_reg[7:3])
    else $error("forced amplifier not passing slice count");
  chk_trim_drive: assert property (
    $stable(t_reg) [*3] |-> pa_max_drive_o == t_reg[TXSER_MAXDRV_BIT])
    else $error("max drive output differs from trim bit");
  chk_ook_nodev: assert property (
    (!c_reg[TXSER_FSK_BIT]) [*3] |-> fsk_dev_o == 7'h00)
    else $error("deviation driven in on-off keying");
  chk_force_dev: assert property (
    (c_reg[TXSER_FSK_BIT] && c_reg[TXSER_FDEV_BIT]) [*3]
    |-> fsk_dev_o == DEV_OFFSET)
    else $error("forced deviation not applied");
  chk_off_quiet: assert property (
    (!c_reg[TXSER_EN_BIT]) [*3] |-> !sym_o)
    else $error("symbol output while disabled");
  chk_status_empty: assert property (
    addr_i == TXSER_STATUS_ADDR |=> rdata_o[0] == empty_o)
    else $error("status empty bit differs from flag");
  chk_fsk_follow: assert property (
    (c_reg[TXSER_FSK_BIT] && !c_reg[TXSER_FDEV_BIT]) [*2]
    |-> fsk_dev_o == (sym_o ? DEV_OFFSET : 7'h00))
    else $error("deviation does not follow symbol");
endmodule

bind txser_top txser_checker #(.DEV_OFFSET(DEV_OFFSET)) u_chk (
  .mclk_i, .nrst_i, .addr_i, .wr_i, .wdata_i, .rdata_o, .pa_on_o,
  .pa_slices_o, .pa_max_drive_o, .div_on_o, .osc_on_o, .fsk_dev_o,
  .sym_o, .empty_o
);

// ==== tb/txser_fw_model.sv ====
module txser_fw_model
  import txser_pkg::*;
(
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  input wire logic empty_i,
  output logic [15:0] addr_o,
  output logic wr_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_o = 16'h0000;
    wr_o = 1'b0;
    wdata_o = 8'h00;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge mclk_i);
    wr_o = 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    addr_o = a;
    @(negedge mclk_i);
    d = rdata_i;
  endtask
  // other trim bits belong to other owners, so keep them as read
  task automatic set_drive(input logic b);
    logic [7:0] v;
    rd(TXSER_TRIM_ADDR, v);
    v[TXSER_MAXDRV_BIT] = b;
    wr(TXSER_TRIM_ADDR, v);
  endtask
  task automatic grp(input logic [7:0] tim, input logic [7:0] d);
    for (int i = 0; i < 4000 && empty_i !== 1'b1; i++) @(negedge mclk_i);
    wr(TXSER_TIMING_ADDR, tim);
    wr(TXSER_DATA_ADDR, d);
  endtask
endmodule

// ==== tb/txser_top_test.sv ====
module txser_top_test
  import txser_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, nrst, wr, pa_on, maxdrv, div_on, osc_on, sym, empty;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, v;
  logic [4:0] slices;
  logic [6:0] dev;
  // arbitrary deviation word, away from the default to exercise the knob
  localparam logic [6:0] DEV_OFFSET = 7'h2a;
  int fails, n_checks;
  txser_top #(.DEV_OFFSET(DEV_OFFSET)) DUT (.mclk_i(mclk), .nrst_i(nrst),
    .addr_i(addr), .wr_i(wr),
    .wdata_i(wdata), .rdata_o(rdata), .pa_on_o(pa_on),
    .pa_slices_o(slices), .pa_max_drive_o(maxdrv), .div_on_o(div_on),
    .osc_on_o(osc_on), .fsk_dev_o(dev), .sym_o(sym), .empty_o(empty));
  txser_fw_model fw (.mclk_i(mclk), .rdata_i(rdata), .empty_i(empty),
    .addr_o(addr), .wr_o(wr), .wdata_o(wdata));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic int ones(input logic [7:0] d, input int w);
    int n = 0;
    for (int i = 0; i <= w; i++) n += d[i];
    return n;
  endfunction
  task automatic complete_run;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // four rounds of traffic need well under 7000 cycles
  initial begin
    #(20000 * 8);
    fails++;
    complete_run();
  end
  initial begin
    int cnt, w1, w2, ck, rt, ex, per;
    logic [7:0] d1, d2;
    logic [1:0] md;
    fails = 0;
    n_checks = 0;
    nrst = 1'b0;
    cnt = $urandom(19564);
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    nrst = 1'b1;
    chk(empty, 8'h01);
    fw.rd(TXSER_CTRL_ADDR, v);
    chk(v, TXSER_CTRL_RST);
    fw.rd(16'h0001, v);
    chk(v, 8'h00);
    fw.set_drive(1'b1);
    repeat (3) @(negedge mclk);
    chk(maxdrv, 8'h01);
    fw.wr(TXSER_LEVEL_ADDR, 8'h08);
    fw.wr(TXSER_CTRL_ADDR, 8'h3e);
    repeat (4) @(negedge mclk);
    chk({pa_on, div_on, osc_on, slices}, 8'he1);
    chk(dev, DEV_OFFSET);
    fw.wr(TXSER_CTRL_ADDR, 8'h00);
    for (int k = 0; k < 4; k++) begin
      md = k[0] ? TXSER_END_ZEROS : TXSER_END_OFF;
      w1 = 1 + $urandom % 7;
      w2 = 1 + $urandom % 7;
      ck = 2 + $urandom % 2;
      rt = 2 + $urandom % 2;
      d1 = $urandom;
      d2 = $urandom;
      fw.wr(TXSER_RATEL_ADDR, rt[7:0]);
      fw.wr(TXSER_RATEH_ADDR, 8'h00);
      fw.wr(TXSER_CTRL_ADDR, {md, 1'b0, k[1], 4'h1});
      cnt = 0;
      fork
        begin
          fw.grp({w1[2:0], 2'b00, ck[2:0]}, d1);
          fw.grp({w2[2:0], 2'b00, ck[2:0]}, d2);
        end
        repeat (900) @(negedge mclk) cnt += sym;
      join
      ex = (ones(d1, w1) + ones(d2, w2)) * rt * (ck + 1);
      chk(cnt[7:0], ex[7:0]);
      chk(empty, 8'h01);
      if (md == TXSER_END_OFF) chk({pa_on, div_on, osc_on}, 8'h00);
      ex = {5'h00, (md == TXSER_END_OFF ? TXSER_IDLE : TXSER_SEND), 1'b1};
      fw.rd(TXSER_STATUS_ADDR, v);
      chk(v, ex[7:0]);
      // third group under repeat or all-ones: one full period is counted
      md = k[0] ? TXSER_END_ONES : TXSER_END_REPEAT;
      fw.wr(TXSER_CTRL_ADDR, {md, 1'b0, k[1], 4'h1});
      fw.grp({w1[2:0], 2'b00, ck[2:0]}, d2);
      repeat (300) @(negedge mclk);
      per = (w1 + 1) * rt * (ck + 1);
      ex = md == TXSER_END_ONES ? per : ones(d2, w1) * rt * (ck + 1);
      cnt = 0;
      repeat (per) @(negedge mclk) cnt += sym;
      chk(cnt[7:0], ex[7:0]);
      fw.wr(TXSER_CTRL_ADDR, 8'h00);
    end
    complete_run();
  end
endmodule
